// File: rtl/cgrf_core.sv
// Purpose: Core general register file with status words and context walk.
// Assumes: Pipeline drives ports on core_clk; at most one context walk at a time.
// Notes:   All reads are registered; a same-cycle wr_en write is forwarded into the read, but stack pointer, return link and restore writes are not.
`timescale 1ns/10ps
module cgrf_core #(
  parameter logic [31:0] STATUS_WRITABLE_MASK       = 32'hffff_ffff,
  parameter logic [31:0] CONTEXT_INFO_WRITABLE_MASK = 32'hffff_ffff
) (
  input  wire logic                         core_clk,
  input  wire logic                         rst,
  input  wire logic [1:0]                   rd_en,
  input  wire logic [1:0]                   rd_is_addr,
  input  wire logic [1:0]                   rd_implicit,
  input  wire logic [7:0]                   rd_idx,
  output logic [2*cgrf_pkg::CGRF_WIDTH-1:0] rd_data,
  output logic [1:0]                        rd_valid,
  input  wire logic                         wr_en,
  input  wire logic                         wr_is_addr,
  input  wire logic                         wr_implicit,
  input  wire logic [cgrf_pkg::CGRF_IDX_W-1:0] wr_idx,
  input  wire logic [cgrf_pkg::CGRF_BYTES-1:0] wr_byte_en,
  input  wire logic [cgrf_pkg::CGRF_WIDTH-1:0] wr_data,
  input  wire logic                         stack_pointer_wr_en,
  input  wire logic [cgrf_pkg::CGRF_WIDTH-1:0] stack_pointer_wr_data,
  input  wire logic                         return_link_wr_en,
  input  wire logic [cgrf_pkg::CGRF_WIDTH-1:0] return_link_wr_data,
  output logic [cgrf_pkg::CGRF_WIDTH-1:0]   stack_pointer,
  output logic [cgrf_pkg::CGRF_WIDTH-1:0]   return_link,
  input  wire logic                         program_status_word_wr_en,
  input  wire logic [cgrf_pkg::CGRF_WIDTH-1:0] program_status_word_wr_data,
  input  wire logic [cgrf_pkg::CGRF_WIDTH-1:0] status_flag_mask,
  input  wire logic [cgrf_pkg::CGRF_WIDTH-1:0] status_flag_value,
  input  wire logic                         previous_context_info_wr_en,
  input  wire logic [cgrf_pkg::CGRF_WIDTH-1:0] previous_context_info_wr_data,
  output logic [cgrf_pkg::CGRF_WIDTH-1:0]   program_status_word,
  output logic [cgrf_pkg::CGRF_WIDTH-1:0]   previous_context_info,
  input  wire logic                         ctx_start,
  input  wire logic                         ctx_upper,
  input  wire logic                         ctx_restore,
  input  wire logic                         ctx_in_valid,
  input  wire logic [cgrf_pkg::CGRF_WIDTH-1:0] ctx_in_data,
  output logic                              ctx_busy,
  output logic                              ctx_done,
  output logic                              ctx_out_valid,
  output logic                              ctx_out_is_addr,
  output logic [cgrf_pkg::CGRF_IDX_W-1:0]   ctx_out_idx,
  output logic [cgrf_pkg::CGRF_WIDTH-1:0]   ctx_out_data
);
  import cgrf_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Storage and context walk.

  logic [CGRF_WIDTH-1:0] data_reg [CGRF_NUM_REGS];
  logic [CGRF_WIDTH-1:0] addr_reg [CGRF_NUM_REGS];
  logic [CGRF_WIDTH-1:0] status_word_reg;
  logic [CGRF_WIDTH-1:0] context_info_reg;

  logic                  restore_reg;
  logic                  seq_busy;
  logic                  seq_is_addr;
  logic [CGRF_IDX_W-1:0] seq_idx;
  logic                  seq_done;
  logic                  seq_advance;
  logic                  restore_write;
  logic [CGRF_IDX_W-1:0] wr_target;

  assign restore_write = seq_busy && restore_reg && ctx_in_valid;
  assign seq_advance   = seq_busy && (!restore_reg || ctx_in_valid);
  assign wr_target     = cgrf_resolve_idx(wr_implicit, wr_idx);

  cgrf_ctx_seq u_seq (
    .core_clk     (core_clk),
    .rst          (rst),
    .start        (ctx_start),
    .upper        (ctx_upper),
    .advance      (seq_advance),
    .busy         (seq_busy),
    .step_is_addr (seq_is_addr),
    .step_idx     (seq_idx),
    .done         (seq_done)
  );

  always_ff @(posedge core_clk) begin
    if (rst) begin
      restore_reg <= 1'b0;
    end else if (ctx_start && !seq_busy) begin
      restore_reg <= ctx_restore;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // General register writes; later sources in this block win on a clash.

  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < CGRF_NUM_REGS; i++) begin
        data_reg[i] <= CGRF_REG_RESET;
        addr_reg[i] <= CGRF_REG_RESET;
      end
    end else begin
      if (wr_en && !wr_is_addr) begin
        data_reg[wr_target] <= cgrf_merge_bytes(data_reg[wr_target], wr_data, wr_byte_en);
      end
      if (wr_en && wr_is_addr) begin
        addr_reg[wr_target] <= cgrf_merge_bytes(addr_reg[wr_target], wr_data, wr_byte_en);
      end
      if (stack_pointer_wr_en) begin
        addr_reg[CGRF_STACK_PTR_IDX] <= stack_pointer_wr_data;
      end
      if (return_link_wr_en) begin
        addr_reg[CGRF_RETURN_LINK_IDX] <= return_link_wr_data;
      end
      if (restore_write && !seq_is_addr) begin
        data_reg[seq_idx] <= ctx_in_data;
      end
      if (restore_write && seq_is_addr && !cgrf_is_global(seq_idx)) begin
        addr_reg[seq_idx] <= ctx_in_data;
      end
    end
  end

  assign stack_pointer = addr_reg[CGRF_STACK_PTR_IDX];
  assign return_link   = addr_reg[CGRF_RETURN_LINK_IDX];

  ////////////////////////////////////////////////////////////////////////////////
  // Read ports with forwarding of the wr_en port write made in the same cycle.

  logic [CGRF_WIDTH-1:0] rd_data_reg [2];
  logic [1:0]            rd_valid_reg;

  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_rd
      logic [CGRF_IDX_W-1:0] idx;
      logic [CGRF_WIDTH-1:0] stored;
      logic                  hit;
      assign idx    = cgrf_resolve_idx(rd_implicit[p], rd_idx[p*4 +: 4]);
      assign stored = rd_is_addr[p] ? addr_reg[idx] : data_reg[idx];
      assign hit    = wr_en && (wr_is_addr == rd_is_addr[p]) && (wr_target == idx);

      always_ff @(posedge core_clk) begin
        if (rst) begin
          rd_data_reg[p]  <= CGRF_REG_RESET;
          rd_valid_reg[p] <= 1'b0;
        end else begin
          rd_valid_reg[p] <= rd_en[p];
          if (rd_en[p]) begin
            rd_data_reg[p] <= hit ? cgrf_merge_bytes(stored, wr_data, wr_byte_en) : stored;
          end
        end
      end
      assign rd_data[p*CGRF_WIDTH +: CGRF_WIDTH] = rd_data_reg[p];
    end
  endgenerate

  assign rd_valid = rd_valid_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // System words; hardware flag updates win over software writes bit by bit.

  always_ff @(posedge core_clk) begin
    if (rst) begin
      status_word_reg <= CGRF_STATUS_RESET;
    end else begin
      status_word_reg <= ((program_status_word_wr_en ? (program_status_word_wr_data & STATUS_WRITABLE_MASK)
                                                     : status_word_reg)
                          & ~status_flag_mask) | (status_flag_value & status_flag_mask);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      context_info_reg <= CGRF_CONTEXT_INFO_RESET;
    end else if (previous_context_info_wr_en) begin
      context_info_reg <= previous_context_info_wr_data & CONTEXT_INFO_WRITABLE_MASK;
    end
  end

  assign program_status_word   = status_word_reg;
  assign previous_context_info = context_info_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Context save stream and status.

  logic                  ctx_busy_reg;
  logic                  ctx_done_reg;
  logic                  ctx_out_valid_reg;
  logic                  ctx_out_is_addr_reg;
  logic [CGRF_IDX_W-1:0] ctx_out_idx_reg;
  logic [CGRF_WIDTH-1:0] ctx_out_data_reg;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctx_busy_reg        <= 1'b0;
      ctx_done_reg        <= 1'b0;
      ctx_out_valid_reg   <= 1'b0;
      ctx_out_is_addr_reg <= 1'b0;
      ctx_out_idx_reg     <= 4'h0;
      ctx_out_data_reg    <= CGRF_REG_RESET;
    end else begin
      ctx_busy_reg      <= seq_busy;
      ctx_done_reg      <= seq_done;
      ctx_out_valid_reg <= seq_busy && !restore_reg;
      if (seq_busy && !restore_reg) begin
        ctx_out_is_addr_reg <= seq_is_addr;
        ctx_out_idx_reg     <= seq_idx;
        ctx_out_data_reg    <= seq_is_addr ? addr_reg[seq_idx] : data_reg[seq_idx];
      end
    end
  end

  assign ctx_busy        = ctx_busy_reg;
  assign ctx_done        = ctx_done_reg;
  assign ctx_out_valid   = ctx_out_valid_reg;
  assign ctx_out_is_addr = ctx_out_is_addr_reg;
  assign ctx_out_idx     = ctx_out_idx_reg;
  assign ctx_out_data    = ctx_out_data_reg;

endmodule

// File: shared/cgrf_pkg.sv
// Purpose: Constants, types and shared decoding for the core general register file.
// Assumes: Single core clock, synchronous active-high reset.
// Notes:   Registers are reset to zero, but software must not rely on that value.
package cgrf_pkg;

  localparam int unsigned CGRF_WIDTH = 32;
  localparam int unsigned CGRF_NUM_REGS = 16;
  localparam int unsigned CGRF_IDX_W = 4;
  localparam int unsigned CGRF_BYTES = 4;

  localparam logic [3:0] CGRF_IMPLICIT_IDX = 4'hf;
  localparam logic [3:0] CGRF_STACK_PTR_IDX = 4'ha;
  localparam logic [3:0] CGRF_RETURN_LINK_IDX = 4'hb;
  localparam logic [3:0] CGRF_LAST_STEP = 4'hf;
  localparam logic [3:0] CGRF_LAST_DATA_STEP = 4'h7;
  localparam logic [3:0] CGRF_FIRST_LOCAL_ADDR_STEP = 4'ha;
  localparam logic [15:0] CGRF_GLOBAL_MASK = 16'h0303;

  localparam logic [31:0] CGRF_REG_RESET = 32'h0000_0000;
  localparam logic [31:0] CGRF_STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] CGRF_CONTEXT_INFO_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    CGRF_SEQ_IDLE = 2'b01,
    CGRF_SEQ_RUN  = 2'b10
  } cgrf_seq_state_t;

  // Global address registers sit outside both context halves.
  function automatic logic cgrf_is_global(input logic [3:0] idx);
    return CGRF_GLOBAL_MASK[idx];
  endfunction

  // An implicit operand always resolves to index 15.
  function automatic logic [3:0] cgrf_resolve_idx(input logic implicit_sel, input logic [3:0] idx);
    return implicit_sel ? CGRF_IMPLICIT_IDX : idx;
  endfunction

  // Byte lane 0 carries bits 7:0, so lanes follow little-endian order.
  function automatic logic [31:0] cgrf_merge_bytes(input logic [31:0] old_val, input logic [31:0] new_val,
                                                   input logic [3:0] byte_en);
    logic [31:0] merged;
    merged = old_val;
    for (int b = 0; b < 4; b++) begin
      if (byte_en[b]) begin
        merged[b*8 +: 8] = new_val[b*8 +: 8];
      end
    end
    return merged;
  endfunction

endpackage

// File: rtl/cgrf_ctx_seq.sv
// Purpose: Walks the registers of one context half for save or restore.
// Assumes: The caller advances one step per accepted word.
// Notes:   Eight data steps, then six address steps; the two global ones are skipped.
`timescale 1ns/10ps
module cgrf_ctx_seq (
  input  wire logic                        core_clk,
  input  wire logic                        rst,
  input  wire logic                        start,
  input  wire logic                        upper,
  input  wire logic                        advance,
  output logic                             busy,
  output logic                             step_is_addr,
  output logic [cgrf_pkg::CGRF_IDX_W-1:0]  step_idx,
  output logic                             done
);
  import cgrf_pkg::*;

  cgrf_seq_state_t state_reg;
  logic [3:0]      step_reg;
  logic            half_reg;
  logic            done_reg;

  assign busy         = (state_reg == CGRF_SEQ_RUN);
  assign step_is_addr = step_reg[3];
  assign step_idx     = {half_reg, step_reg[2:0]};
  assign done         = done_reg;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg <= CGRF_SEQ_IDLE;
      step_reg  <= 4'h0;
      half_reg  <= 1'b0;
      done_reg  <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      unique case (state_reg)
        CGRF_SEQ_IDLE: begin
          if (start) begin
            state_reg <= CGRF_SEQ_RUN;
            step_reg  <= 4'h0;
            half_reg  <= upper;
          end
        end
        CGRF_SEQ_RUN: begin
          if (advance) begin
            if (step_reg == CGRF_LAST_STEP) begin
              state_reg <= CGRF_SEQ_IDLE;
              done_reg  <= 1'b1;
            end else if (step_reg == CGRF_LAST_DATA_STEP) begin
              step_reg <= CGRF_FIRST_LOCAL_ADDR_STEP;
            end else begin
              step_reg <= step_reg + 4'h1;
            end
          end
        end
        default: begin
          state_reg <= CGRF_SEQ_IDLE;
        end
      endcase
    end
  end

endmodule

// File: tb/cgrf_core_props.sv
// Purpose: Port-level checks for the core general register file.
// Assumes: Sees only cgrf_core ports; ctx_restore is held through a walk.
// Notes:   Bound from the testbench top file.
`timescale 1ns/10ps
module cgrf_core_props (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic [1:0]  rd_en,
  input wire logic [1:0]  rd_valid,
  input wire logic        stack_pointer_wr_en,
  input wire logic [31:0] stack_pointer_wr_data,
  input wire logic [31:0] stack_pointer,
  input wire logic        program_status_word_wr_en,
  input wire logic [31:0] program_status_word_wr_data,
  input wire logic [31:0] status_flag_mask,
  input wire logic [31:0] status_flag_value,
  input wire logic [31:0] program_status_word,
  input wire logic        ctx_restore,
  input wire logic        ctx_busy,
  input wire logic        ctx_done,
  input wire logic        ctx_out_valid,
  input wire logic        ctx_out_is_addr,
  input wire logic [3:0]  ctx_out_idx
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_read_answer: assert property (rd_en[1] |=> rd_valid[1])
    else $error("read answer missing");
  a_read_quiet: assert property (!rd_en[0] |=> !rd_valid[0])
    else $error("read valid without request");
  a_stack_port: assert property (stack_pointer_wr_en && !ctx_busy |=>
    stack_pointer == $past(stack_pointer_wr_data)) else $error("stack pointer not written");
  a_status_soft: assert property (program_status_word_wr_en |=>
    ((program_status_word ^ $past(program_status_word_wr_data)) & ~$past(status_flag_mask)) == 32'h0)
    else $error("status word write lost");
  a_status_flag: assert property (|status_flag_mask |=>
    ((program_status_word ^ $past(status_flag_value)) & $past(status_flag_mask)) == 32'h0)
    else $error("hardware flag not shown");
  a_save_walk: assert property ($rose(ctx_busy) && !ctx_restore |->
    (ctx_busy && ctx_out_valid)[*8] ##1 (ctx_busy && ctx_out_valid)[*6] ##1 (ctx_done && !ctx_busy))
    else $error("save walk length wrong");
  a_save_global: assert property (ctx_out_valid |-> !(ctx_out_is_addr && ctx_out_idx[2:1] == 2'h0))
    else $error("global register saved");
  a_done_pulse: assert property (ctx_done |=> !ctx_done && !ctx_busy && !ctx_out_valid)
    else $error("done not a single pulse");
  c_save: cover property ($rose(ctx_busy) && !ctx_restore);
  c_restore: cover property (ctx_done && ctx_restore);
  c_flag: cover property (program_status_word_wr_en && |status_flag_mask);
endmodule

// File: tb/cgrf_pipe_model.sv
// Purpose: Pipeline-side model that feeds the fourteen context restore words.
// Assumes: go pulses with ctx_start; slow leaves an idle cycle between words.
// Notes:   Idle data inverts the previous cycle's value, so a single idle cycle never matches the last word.
`timescale 1ns/10ps
module cgrf_pipe_model (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        go,
  input  wire logic        slow,
  output logic             ctx_in_valid,
  output logic [31:0]      ctx_in_data
);
  logic [4:0] k_reg;
  logic       gap_reg;
  logic       send;
  assign send = !rst && !go && (k_reg < 5'h0e) && !(slow && gap_reg);
  always_ff @(posedge core_clk) begin
    k_reg <= rst ? 5'h0e : (go ? 5'h00 : k_reg + {4'h0, send});
    gap_reg <= !rst && !gap_reg;
    ctx_in_valid <= send;
    ctx_in_data <= rst ? 32'h0 : (send ? 32'hc0de_0000 + {27'h0, k_reg} : ~ctx_in_data);
  end
endmodule

// File: tb/cgrf_core_tb.sv
// Purpose: Self-checking bench for the core general register file.
// Assumes: Inputs change at the falling edge; ctx_restore is held through a walk.
// Notes:   Every register is seeded before saved words are compared.
`timescale 1ns/10ps
module cgrf_core_tb;
  import cgrf_pkg::*;
  logic        core_clk = 0, rst = 1, wr_en = 0, wr_is_addr = 0, wr_implicit = 0, go = 0, slow = 0;
  logic        stack_pointer_wr_en = 0, return_link_wr_en = 0, program_status_word_wr_en = 0;
  logic        previous_context_info_wr_en = 0, ctx_start = 0, ctx_upper = 0, ctx_restore = 0;
  logic        ctx_in_valid, ctx_busy, ctx_done, ctx_out_valid, ctx_out_is_addr;
  logic [1:0]  rd_en = 0, rd_is_addr = 0, rd_implicit = 0, rd_valid;
  logic [3:0]  wr_idx = 0, wr_byte_en = 0, ctx_out_idx;
  logic [7:0]  rd_idx = 0;
  logic [31:0] wr_data = 0, stack_pointer_wr_data = 0, return_link_wr_data = 0, status_flag_mask = 0;
  logic [31:0] status_flag_value = 0, program_status_word_wr_data = 0, previous_context_info_wr_data = 0;
  logic [31:0] ctx_in_data, ctx_out_data, stack_pointer, return_link, program_status_word, previous_context_info;
  logic [63:0] rd_data;
  int          mismatches = 0, samples_checked = 0, cycles = 0;

  cgrf_core       cgrf_core_inst (.*);
  cgrf_pipe_model cgrf_pipe_model_inst (.*);

  initial forever #5 core_clk = ~core_clk;

  task automatic end_sim();
    $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      $display("[FAIL] %0t timeout", $time);
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  function automatic logic [31:0] val(input logic a, input logic [3:0] i);
    return {24'h5a0000, 3'h0, a, i};
  endfunction

  task automatic ws(input logic a, input logic [3:0] i, input logic [3:0] be, input logic [31:0] d);
    wr_en = 1;
    wr_is_addr = a;
    wr_idx = i;
    wr_byte_en = be;
    wr_data = d;
  endtask

  task automatic rd(input int p, input logic a, input logic [3:0] i, input logic [31:0] e);
    rd_en = (p != 0) ? 2'b10 : 2'b01;
    rd_is_addr[p] = a;
    rd_idx[4*p +: 4] = i;
    @(negedge core_clk);
    chk({31'h0, rd_valid[p]}, 32'h1, "read valid");
    chk(rd_data[32*p +: 32], e, "read data");
  endtask

  task automatic t_all();
    for (int n = 0; n < 32; n++) begin
      ws(n[4], n[3:0], 4'hf, val(n[4], n[3:0]));
      @(negedge core_clk);
    end
    wr_en = 0;
    for (int n = 0; n < 32; n++) rd(n % 2, n[4], n[3:0], val(n[4], n[3:0]));
  endtask

  task automatic t_save(input logic u);
    int         k;
    int         d;
    logic [3:0] i;
    k = 0;
    d = 0;
    rd_en = 0;
    ctx_upper = u;
    ctx_start = 1;
    @(negedge core_clk);
    ctx_start = 0;
    repeat (20) begin
      @(negedge core_clk);
      d += int'(ctx_done === 1'b1);
      if (ctx_out_valid === 1'b1) begin
        i = {u, 3'(k > 7 ? k - 6 : k)};
        chk({27'h0, ctx_out_is_addr, ctx_out_idx}, {27'h0, k > 7, i}, "save slot");
        chk(ctx_out_data, val(k > 7, i), "save word");
        k++;
      end
    end
    chk(k, 14, "save count");
    chk(d, 1, "save done");
  endtask

  task automatic t_restore();
    int n;
    n = 0;
    ctx_restore = 1;
    ctx_upper = 0;
    slow = 1;
    ctx_start = 1;
    go = 1;
    @(negedge core_clk);
    ctx_start = 0;
    go = 0;
    while (ctx_done !== 1'b1 && n < 80) begin
      @(negedge core_clk);
      n++;
    end
    chk(n, n % 80, "restore done");
    ctx_restore = 0;
    for (n = 0; n < 14; n++) rd(n % 2, n > 7, 4'(n > 7 ? n - 6 : n), 32'hc0de_0000 + n);
    rd(0, 1, 4'h0, val(1, 4'h0));
    rd(1, 1, 4'h1, val(1, 4'h1));
  endtask

  task automatic t_paths();
    ws(0, 4'hc, 4'h6, 32'haabb_ccdd);
    @(negedge core_clk);
    ws(1, 4'h3, 4'hf, 32'hfeed_0003);
    rd(1, 1, 4'h3, 32'hfeed_0003);
    wr_en = 0;
    wr_implicit = 1;
    rd(0, 0, 4'hc, 32'h5abb_cc0c);
    ws(0, 4'h0, 4'hf, 32'h1d15_0000);
    rd_implicit = 2'b01;
    rd(0, 1, 4'h0, val(1, 4'hf));
    wr_en = 0;
    wr_implicit = 0;
    rd_implicit = 0;
    rd(1, 0, 4'hf, 32'h1d15_0000);
  endtask

  task automatic t_ports();
    ws(1, 4'ha, 4'hf, 32'hdead_beef);
    stack_pointer_wr_en = 1;
    stack_pointer_wr_data = 32'h0005_7ac0;
    return_link_wr_en = 1;
    return_link_wr_data = 32'h0011_4e70;
    program_status_word_wr_en = 1;
    program_status_word_wr_data = 32'h0000_00f0;
    status_flag_mask = 32'h0000_0011;
    status_flag_value = 32'h0000_0001;
    previous_context_info_wr_en = 1;
    previous_context_info_wr_data = 32'h0012_3400;
    @(negedge core_clk);
    wr_en = 0;
    stack_pointer_wr_en = 0;
    return_link_wr_en = 0;
    program_status_word_wr_en = 0;
    previous_context_info_wr_en = 0;
    status_flag_mask = 0;
    chk(stack_pointer, 32'h0005_7ac0, "stack pointer");
    chk(return_link, 32'h0011_4e70, "return link");
    chk(program_status_word, 32'h0000_00e1, "status word");
    chk(previous_context_info, 32'h0012_3400, "context info");
    rd(0, 1, 4'ha, 32'h0005_7ac0);
    rd(1, 1, 4'hb, 32'h0011_4e70);
  endtask

  initial begin
    repeat (16) @(negedge core_clk);
    rst = 0;
    @(negedge core_clk);
    t_all();
    t_save(1'b0);
    t_save(1'b1);
    t_restore();
    t_paths();
    t_ports();
    end_sim();
  end
endmodule

bind cgrf_core cgrf_core_props cgrf_core_props_inst (.*);
